// *** bench/test_u_maintenance_channel_eoc.sv ***
`timescale 1ns/1ns
module test_u_maintenance_channel_eoc;
  import umc_pkg::*;
  typedef struct packed {
    logic [11:0] word;
    logic [7:0]  info;
    logic [6:0]  loop;
  } umc_row_type;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  umc_axi_req_type    req = '0;
  umc_axi_rsp_type    rsp;
  umc_line_state_type lstate = LS_TRANSPARENT;
  umc_frm_in_type     frm;
  umc_tx_type         txm;
  umc_loop_type       lctl;
  logic               irq;
  logic               sf_on = 1'b0;
  logic               norm_on = 1'b1;
  logic [2:0]         go = 3'h0;
  logic [11:0]        mval = 12'h000;
  logic [31:0]        rd;
  logic [1:0]         resp;
  logic [11:0]        exp_rx;
  logic [6:0]         lvec;
  int                 n_errors = 0;
  int                 num_checks = 0;
  umc_row_type rows [10] = '{
    '{12'h150, 8'h50, 7'h41}, '{12'hF51, 8'h51, 7'h4B}, '{12'h152, 8'h52, 7'h4F},
    '{12'h153, 8'h53, 7'h5F}, '{12'h154, 8'h54, 7'h7F}, '{12'h1FF, 8'hFF, 7'h00},
    '{12'h750, 8'h00, 7'h00}, '{12'h050, 8'hAA, 7'h00}, '{12'h177, 8'hAA, 7'h00},
    '{12'h100, 8'h00, 7'h00}};
  logic [7:0]  rst_adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20};
  logic [31:0] rst_val [8] = '{32'hFF, 32'hFF, 32'h3, 32'hFF, 32'hFF, 32'h3, 32'h1, 32'h0};

  always #5 clk = ~clk;

  // Loop output in loop register bit order
  assign lvec = {lctl.loop_request_indication, lctl.notify_bad_crc_cmd, lctl.request_bad_crc_cmd, lctl.side, lctl.b2, lctl.b1, lctl.full};

  umc_maint_core dut_u (
    .clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp), .line_state(lstate),
    .frm_in(frm), .tx_mbits(txm), .loop_ctl(lctl), .irq(irq));

  umc_lt_model #(.FRAME_CYC(64)) lt_u (
    .clk(clk), .rst_n(rst_n), .sf_on(sf_on), .norm_on(norm_on), .go(go), .val(mval), .frm(frm));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1 && n < 100);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    if (n >= 100) n_errors++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1 && n < 100);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    if (n >= 100) n_errors++;
  endtask : axi_rd

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    axi_rd(a);
    chk(nm, rd & mask, exp);
  endtask : rdchk

  task automatic send(input int k, input logic [11:0] v);
    @(posedge clk);
    go[k] <= 1'b1;
    mval <= v;
    @(posedge clk);
    go[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : send

  task automatic wait_frame(input logic [2:0] f);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!(frm.frame_start && frm.frame_num == f) && n < 2000);
    if (n >= 2000) n_errors++;
  endtask : wait_frame

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("tx clamp idle", 32'(txm), 32'h003F_FFFF);
    for (int i = 0; i < 8; i++)
      rdchk("reset value", rst_adr[i], 32'hFFFF_FFFF, rst_val[i]);
    axi_rd(8'h24);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped rresp", 32'(resp), 32'h2);
    axi_wr(8'h24, 32'h1);
    chk("unmapped bresp", 32'(resp), 32'h2);
    axi_wr(8'h18, 32'h1F);
    foreach (rows[i])
    begin
      send(0, rows[i].word);
      rdchk("eoc rx", 8'h0C, 32'hFFF, 32'(rows[i].word));
      rdchk("eoc reply", 8'h00, 32'hFF, 32'(rows[i].info));
      rdchk("loop reg", 8'h20, 32'h7F, 32'(rows[i].loop));
      chk("loop out", 32'(lvec), 32'(rows[i].loop));
      rdchk("eoc flag", 8'h18, 32'h1, 32'h1);
      axi_wr(8'h18, 32'h1);
    end
    send(0, 12'h100);
    rdchk("eoc repeat", 8'h18, 32'h1, 32'h0);
    send(1, 12'h03C);
    send(2, 12'h001);
    rdchk("m4 rx", 8'h10, 32'hFF, 32'h3C);
    rdchk("m56 rx", 8'h14, 32'h3, 32'h1);
    rdchk("m flags", 8'h18, 32'h6, 32'h6);
    axi_wr(8'h18, 32'h6);
    send(1, 12'h03C);
    rdchk("m4 repeat", 8'h18, 32'h6, 32'h0);
    axi_wr(8'h1C, 32'h0);
    send(0, 12'h150);
    rdchk("manual tx", 8'h00, 32'hFFF, 32'h100);
    rdchk("manual loop", 8'h20, 32'h7F, 32'h0);
    rdchk("manual rx", 8'h0C, 32'hFFF, 32'h150);
    axi_wr(8'h1C, 32'h1);
    exp_rx = 12'h150;
    for (int s = 0; s < 12; s++)
    begin
      lstate <= LS_RESET;
      repeat (3) @(posedge clk);
      lstate <= umc_line_state_type'(s);
      repeat (3) @(posedge clk);
      send(0, 12'h020 + 12'(s));
      if (s >= 3 && s <= 10) exp_rx = 12'h020 + 12'(s);
      rdchk("rx enable", 8'h0C, 32'hFFF, 32'(exp_rx));
    end
    lstate <= LS_RESET;
    repeat (3) @(posedge clk);
    lstate <= LS_SYNC1;
    repeat (3) @(posedge clk);
    rdchk("eoc rx reload", 8'h0C, 32'hFFF, 32'h0FF);
    rdchk("m4 rx reload", 8'h10, 32'hFF, 32'hFF);
    rdchk("m56 rx reload", 8'h14, 32'h3, 32'h3);
    lstate <= LS_TRANSPARENT;
    wait_frame(3'h1);
    axi_wr(8'h18, 32'h1F);
    rdchk("no event", 8'h18, 32'h1F, 32'h0);
    chk("irq idle", 32'(irq), 32'h0);
    wait_frame(3'h4);
    rdchk("6 ms event", 8'h18, 32'h1F, 32'h08);
    chk("irq raised", 32'(irq), 32'h1);
    axi_wr(8'h18, 32'h1F);
    sf_on <= 1'b1;
    wait_frame(3'h0);
    rdchk("12 ms event", 8'h18, 32'h1F, 32'h18);
    axi_wr(8'h04, 32'h5A);
    axi_wr(8'h08, 32'h1);
    axi_wr(8'h00, 32'h123);
    wait_frame(3'h4);
    repeat (2) @(negedge clk);
    chk("eoc tx", 32'(txm.eoc), 32'h123);
    chk("m4 held", 32'(txm.m4), 32'hFF);
    wait_frame(3'h0);
    repeat (2) @(negedge clk);
    chk("m4 next sf", 32'(txm.m4), 32'h5A);
    chk("m56 next sf", 32'(txm.m56), 32'h1);
    @(posedge clk);
    norm_on <= 1'b0;
    repeat (3) @(negedge clk);
    chk("tx clamp", 32'(txm), 32'h003F_FFFF);
    report_and_stop();
  end
endmodule : test_u_maintenance_channel_eoc

// *** bench/umc_lt_model.sv ***
`timescale 1ns/1ns
module umc_lt_model #(
  parameter int FRAME_CYC = 64
)(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    sf_on,
  input  wire logic                    norm_on,
  input  wire logic [2:0]              go,
  input  wire logic [11:0]             val,
  output      umc_pkg::umc_frm_in_type frm
);
  import umc_pkg::*;
  int cnt_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 0;
      frm <= '0;
      frm.frame_num <= 3'h7;
    end
    else
    begin
      cnt_r <= (cnt_r == FRAME_CYC - 1) ? 0 : cnt_r + 1;
      frm.frame_start <= (cnt_r == 0);
      if (cnt_r == 0)
        frm.frame_num <= frm.frame_num + 3'h1;
      frm.sf_active <= sf_on;
      frm.m_normal <= norm_on;
      frm.eoc_valid <= go[0];
      frm.m4_valid <= go[1];
      frm.m56_valid <= go[2];
      // Idle lines toggle so stale values never pass
      frm.eoc_word <= go[0] ? umc_eoc_type'(val) : ~frm.eoc_word;
      frm.m4_bits <= go[1] ? val[7:0] : ~frm.m4_bits;
      frm.m56_bits <= go[2] ? val[1:0] : ~frm.m56_bits;
    end
  end
endmodule : umc_lt_model

// *** hdl/umc_maint_core.sv ***
`timescale 1ns/1ns
// Function
// - Programmed M-bits only when normal, else ones
// - Receive enabled only in listed line states
// - Reset receive bits on entering enabled state
// - Received maintenance information raises interrupt
// - Timing events in basic frames 1, 5
// - M4, M5/M6 writes sent next superframe
// - Each receive register has own flag
// - Receive flags only on value change
// - All flags in one status register
// - EOC word: address, indicator, eight info bits
// - Address 000 NT, 111 broadcast, else repeater
// - Indicator one message, zero numerical data
// - Code 50 full loop, auto loop request
// - Code 51 B1 loop, set side select
// - Code 52 B2 loop, set side select
// - Code 53 invert CRCs, hold error state
// - Code 54 disable near-end error counters
// - Code FF releases commands, resets transmit
// - Hold no change; hold for foreign address
// - Undefined command or data: unable-to-comply
// - Valid addressed command echoed back, except FF
`include "umc_map.svh"
module umc_maint_core (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire umc_pkg::umc_axi_req_type    axi_req,
  output      umc_pkg::umc_axi_rsp_type    axi_rsp,
  input  wire umc_pkg::umc_line_state_type line_state,
  input  wire umc_pkg::umc_frm_in_type     frm_in,
  output      umc_pkg::umc_tx_type         tx_mbits,
  output      umc_pkg::umc_loop_type       loop_ctl,
  output      logic                        irq
);
  import umc_pkg::*;

  typedef struct packed {
    umc_axi_rsp_type rsp;
    logic            aw_held;
    logic [7:0]      aw_addr;
    logic            w_held;
    logic [31:0]     w_data;
    umc_eoc_type     eoc_tx_r;
    logic [7:0]      m4_tx_r;
    logic [1:0]      m56_tx_r;
    umc_eoc_type     eoc_sh_r;
    logic [7:0]      m4_sh_r;
    logic [1:0]      m56_sh_r;
    umc_eoc_type     eoc_rx_r;
    logic [7:0]      m4_rx_r;
    logic [1:0]      m56_rx_r;
    logic [4:0]      status_r;
    logic            auto_r;
    logic            rx_en_r;
    umc_loop_type    loop_r;
    umc_tx_type      tx_r;
    logic            irq_r;
  } umc_state_type;

  umc_state_type st_r;
  umc_state_type st_nxt;

  function automatic logic rx_state_ok(input umc_line_state_type s);
    rx_state_ok = (s == LS_SYNC1) || (s == LS_SYNC2) || (s == LS_WAIT_ACT) ||
                  (s == LS_TRANSPARENT) || (s == LS_ERROR_ST) || (s == LS_PEND_DEAC_ST) ||
                  (s == LS_PEND_DEAC_U) || (s == LS_ANALOG_LOOP);
  endfunction : rx_state_ok

  function automatic logic cmd_defined(input logic [7:0] c);
    cmd_defined = (c == `UMC_CMD_HOLD) || (c == `UMC_CMD_FULL_LOOP) || (c == `UMC_CMD_B1_LOOP) ||
                  (c == `UMC_CMD_B2_LOOP) || (c == `UMC_CMD_REQ_BAD_CRC) ||
                  (c == `UMC_CMD_NOT_BAD_CRC) || (c == `UMC_CMD_RETURN);
  endfunction : cmd_defined

  function automatic logic addr_ours(input logic [2:0] a);
    addr_ours = (a == `UMC_ADDR_NT) || (a == `UMC_ADDR_BCAST);
  endfunction : addr_ours

  function automatic logic [31:0] read_mux(input umc_state_type s, input logic [7:0] a);
    read_mux = 32'h0000_0000;
    if (a == `UMC_OFF_EOC_TX)
      read_mux = {20'h0_0000, s.eoc_tx_r};
    else if (a == `UMC_OFF_M4_TX)
      read_mux = {24'h00_0000, s.m4_tx_r};
    else if (a == `UMC_OFF_M56_TX)
      read_mux = {30'h0000_0000, s.m56_tx_r};
    else if (a == `UMC_OFF_EOC_RX)
      read_mux = {20'h0_0000, s.eoc_rx_r};
    else if (a == `UMC_OFF_M4_RX)
      read_mux = {24'h00_0000, s.m4_rx_r};
    else if (a == `UMC_OFF_M56_RX)
      read_mux = {30'h0000_0000, s.m56_rx_r};
    else if (a == `UMC_OFF_STATUS)
      read_mux = {27'h000_0000, s.status_r};
    else if (a == `UMC_OFF_CTRL)
      read_mux = {31'h0000_0000, s.auto_r};
    else if (a == `UMC_OFF_LOOP)
      read_mux = {25'h000_0000, s.loop_r.loop_request_indication, s.loop_r.notify_bad_crc_cmd, s.loop_r.request_bad_crc_cmd, s.loop_r.side,
                  s.loop_r.b2, s.loop_r.b1, s.loop_r.full};
  endfunction : read_mux

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `UMC_OFF_EOC_TX) || (a == `UMC_OFF_M4_TX) || (a == `UMC_OFF_M56_TX) ||
                  (a == `UMC_OFF_EOC_RX) || (a == `UMC_OFF_M4_RX) || (a == `UMC_OFF_M56_RX) ||
                  (a == `UMC_OFF_STATUS) || (a == `UMC_OFF_CTRL) || (a == `UMC_OFF_LOOP);
  endfunction : addr_mapped

  always_comb
  begin
    logic        rx_now;
    logic        rx_entry;
    logic        do_wr;
    logic [4:0]  set_bits;
    logic [4:0]  clr_bits;
    umc_eoc_type w;
    st_nxt   = st_r;
    rx_now   = rx_state_ok(line_state);
    rx_entry = rx_now && !st_r.rx_en_r;
    set_bits = 5'h00;
    clr_bits = 5'h00;
    w        = frm_in.eoc_word;
    do_wr    = 1'b0;
    st_nxt.rx_en_r = rx_now;

    // Bus write path: address and data in either order
    if (axi_req.awvalid && st_r.rsp.awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.rsp.wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = axi_req.wdata;
    end
    if (st_r.rsp.bvalid && axi_req.bready)
      st_nxt.rsp.bvalid = 1'b0;
    do_wr = st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid;
    if (do_wr)
    begin
      st_nxt.aw_held     = 1'b0;
      st_nxt.w_held      = 1'b0;
      st_nxt.rsp.bvalid  = 1'b1;
      st_nxt.rsp.bresp   = addr_mapped(st_r.aw_addr) ? `UMC_RESP_OKAY : `UMC_RESP_SLVERR;
      if (st_r.aw_addr == `UMC_OFF_EOC_TX)
        st_nxt.eoc_tx_r = st_r.w_data[11:0];
      else if (st_r.aw_addr == `UMC_OFF_M4_TX)
        st_nxt.m4_tx_r = st_r.w_data[7:0];
      else if (st_r.aw_addr == `UMC_OFF_M56_TX)
        st_nxt.m56_tx_r = st_r.w_data[1:0];
      else if (st_r.aw_addr == `UMC_OFF_STATUS)
        clr_bits = st_r.w_data[4:0];
      else if (st_r.aw_addr == `UMC_OFF_CTRL)
        st_nxt.auto_r = st_r.w_data[`UMC_CTRL_AUTO];
    end
    st_nxt.rsp.awready = !st_nxt.aw_held && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready  = !st_nxt.w_held && !st_nxt.rsp.bvalid;

    // Bus read path
    if (st_r.rsp.rvalid && axi_req.rready)
      st_nxt.rsp.rvalid = 1'b0;
    if (axi_req.arvalid && st_r.rsp.arready)
    begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata  = read_mux(st_r, axi_req.araddr);
      st_nxt.rsp.rresp  = addr_mapped(axi_req.araddr) ? `UMC_RESP_OKAY : `UMC_RESP_SLVERR;
    end
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

    // Superframe timing and transmit shadow loads
    if (frm_in.frame_start && frm_in.frame_num == `UMC_FRAME_FIRST)
    begin
      set_bits[`UMC_ST_T6]  = 1'b1;
      set_bits[`UMC_ST_T12] = 1'b1;
      st_nxt.m4_sh_r  = st_nxt.m4_tx_r;
      st_nxt.m56_sh_r = st_nxt.m56_tx_r;
      st_nxt.eoc_sh_r = st_nxt.eoc_tx_r;
    end
    else if (frm_in.frame_start && frm_in.frame_num == `UMC_FRAME_FIFTH)
    begin
      set_bits[`UMC_ST_T6] = 1'b1;
      st_nxt.eoc_sh_r = st_nxt.eoc_tx_r;
    end

    // Receive path
    if (rx_entry)
    begin
      st_nxt.eoc_rx_r = `UMC_RST_EOC_RX;
      st_nxt.m4_rx_r  = `UMC_RST_M4;
      st_nxt.m56_rx_r = `UMC_RST_M56;
    end
    else if (rx_now)
    begin
      if (frm_in.m4_valid && frm_in.m4_bits != st_r.m4_rx_r)
      begin
        st_nxt.m4_rx_r      = frm_in.m4_bits;
        set_bits[`UMC_ST_M4] = 1'b1;
      end
      if (frm_in.m56_valid && frm_in.m56_bits != st_r.m56_rx_r)
      begin
        st_nxt.m56_rx_r      = frm_in.m56_bits;
        set_bits[`UMC_ST_M56] = 1'b1;
      end
      if (frm_in.eoc_valid)
      begin
        if (w != st_r.eoc_rx_r)
        begin
          st_nxt.eoc_rx_r       = w;
          set_bits[`UMC_ST_EOC] = 1'b1;
        end
        if (st_r.auto_r)
        begin
          if (!addr_ours(w.addr))
            st_nxt.eoc_tx_r = {`UMC_ADDR_NT, 1'b1, `UMC_CMD_HOLD};
          else if (!w.dm || !cmd_defined(w.info))
            st_nxt.eoc_tx_r = {`UMC_ADDR_NT, 1'b1, `UMC_CMD_UNABLE};
          else
          begin
            st_nxt.eoc_tx_r = w;
            case (w.info)
              `UMC_CMD_FULL_LOOP:
              begin
                st_nxt.loop_r.full = 1'b1;
                st_nxt.loop_r.loop_request_indication  = 1'b1;
              end
              `UMC_CMD_B1_LOOP:
              begin
                st_nxt.loop_r.b1   = 1'b1;
                st_nxt.loop_r.side = 1'b1;
              end
              `UMC_CMD_B2_LOOP:
              begin
                st_nxt.loop_r.b2   = 1'b1;
                st_nxt.loop_r.side = 1'b1;
              end
              `UMC_CMD_REQ_BAD_CRC:
                st_nxt.loop_r.request_bad_crc_cmd = 1'b1;
              `UMC_CMD_NOT_BAD_CRC:
                st_nxt.loop_r.notify_bad_crc_cmd = 1'b1;
              `UMC_CMD_RETURN:
              begin
                st_nxt.loop_r   = '0;
                st_nxt.eoc_tx_r = `UMC_RST_EOC_TX;
              end
              default:
                st_nxt.loop_r = st_r.loop_r;
            endcase
          end
        end
      end
    end

    // Sticky flags: set wins over clear
    st_nxt.status_r = (st_r.status_r & ~clr_bits) | set_bits;
    st_nxt.irq_r    = |st_nxt.status_r;

    // Transmit clamp
    if (frm_in.sf_active && frm_in.m_normal)
      st_nxt.tx_r = {st_nxt.eoc_sh_r, st_nxt.m4_sh_r, st_nxt.m56_sh_r};
    else
      st_nxt.tx_r = '1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r             <= '0;
      st_r.eoc_tx_r    <= `UMC_RST_EOC_TX;
      st_r.m4_tx_r     <= `UMC_RST_M4;
      st_r.m56_tx_r    <= `UMC_RST_M56;
      st_r.eoc_sh_r    <= `UMC_RST_EOC_TX;
      st_r.m4_sh_r     <= `UMC_RST_M4;
      st_r.m56_sh_r    <= `UMC_RST_M56;
      st_r.eoc_rx_r    <= `UMC_RST_EOC_RX;
      st_r.m4_rx_r     <= `UMC_RST_M4;
      st_r.m56_rx_r    <= `UMC_RST_M56;
      st_r.auto_r      <= `UMC_RST_CTRL;
      st_r.tx_r        <= '1;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready  <= 1'b1;
      st_r.rsp.arready <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign axi_rsp  = st_r.rsp;
  assign tx_mbits = st_r.tx_r;
  assign loop_ctl = st_r.loop_r;
  assign irq      = st_r.irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence frame_one_s;
    frm_in.frame_start && frm_in.frame_num == `UMC_FRAME_FIRST;
  endsequence
  sequence good_cmd_s(logic [7:0] c);
    rx_state_ok(line_state) && st_r.rx_en_r && st_r.auto_r && frm_in.eoc_valid &&
      addr_ours(frm_in.eoc_word.addr) && frm_in.eoc_word.dm && frm_in.eoc_word.info == c;
  endsequence
  sequence frame_five_s;
    frm_in.frame_start && frm_in.frame_num == `UMC_FRAME_FIFTH;
  endsequence

  tx_clamp_ones_a: assert property (
      !(frm_in.sf_active && frm_in.m_normal) |=> tx_mbits == '1)
    else $error("M-bits not clamped high");
  eoc_shadow_a: assert property (
      frame_five_s ##1 (frm_in.sf_active && frm_in.m_normal) |=> tx_mbits.eoc == $past(st_r.eoc_sh_r))
    else $error("EOC not taken at frame five");
  m4_next_sf_a: assert property (
      frame_one_s ##1 (frm_in.sf_active && frm_in.m_normal) |=> tx_mbits.m4 == $past(st_r.m4_sh_r))
    else $error("M4 not taken at superframe start");

  rx_reset_load_a: assert property (
      rx_state_ok(line_state) && !st_r.rx_en_r
      |=> st_r.eoc_rx_r == `UMC_RST_EOC_RX && st_r.m4_rx_r == `UMC_RST_M4 && st_r.m56_rx_r == `UMC_RST_M56)
    else $error("Receive bits not reset on entry");
  entry_quiet_a: assert property (
      rx_state_ok(line_state) && !st_r.rx_en_r && st_r.status_r[`UMC_ST_M56:`UMC_ST_EOC] == 3'b000
      |=> st_r.status_r[`UMC_ST_M56:`UMC_ST_EOC] == 3'b000)
    else $error("Flag raised on receive entry");
  rx_gate_a: assert property (
      !rx_state_ok(line_state) |=> $stable(st_r.eoc_rx_r))
    else $error("Receive accepted in disabled state");
  eoc_change_a: assert property (
      $changed(st_r.eoc_rx_r) && $past(st_r.rx_en_r) && $past(frm_in.eoc_valid) |-> st_r.status_r[`UMC_ST_EOC])
    else $error("EOC change not flagged");
  m4_flag_a: assert property (
      rx_state_ok(line_state) && st_r.rx_en_r && frm_in.m4_valid && frm_in.m4_bits != st_r.m4_rx_r
      |=> st_r.status_r[`UMC_ST_M4] && st_r.m4_rx_r == $past(frm_in.m4_bits))
    else $error("M4 change not flagged");
  m56_flag_a: assert property (
      rx_state_ok(line_state) && st_r.rx_en_r && frm_in.m56_valid && frm_in.m56_bits != st_r.m56_rx_r
      |=> st_r.status_r[`UMC_ST_M56] && st_r.m56_rx_r == $past(frm_in.m56_bits))
    else $error("M5/M6 change not flagged");
  no_change_flag_a: assert property (
      rx_state_ok(line_state) && st_r.rx_en_r && frm_in.m4_valid && frm_in.m4_bits == st_r.m4_rx_r &&
      !st_r.status_r[`UMC_ST_M4] |=> !st_r.status_r[`UMC_ST_M4])
    else $error("M4 flag without change");

  timer_flags_a: assert property (
      frame_one_s |=> st_r.status_r[`UMC_ST_T6] && st_r.status_r[`UMC_ST_T12] && irq)
    else $error("Timing flags not raised");
  timer_five_a: assert property (
      frame_five_s |=> st_r.status_r[`UMC_ST_T6])
    else $error("Frame five timing flag not raised");

  full_loop_a: assert property (
      good_cmd_s(`UMC_CMD_FULL_LOOP)
      |=> loop_ctl.full && loop_ctl.loop_request_indication && st_r.eoc_tx_r.info == `UMC_CMD_FULL_LOOP)
    else $error("Full loop not closed or echoed");
  b1_loop_a: assert property (
      good_cmd_s(`UMC_CMD_B1_LOOP)
      |=> loop_ctl.b1 && loop_ctl.side && st_r.eoc_tx_r == $past(frm_in.eoc_word))
    else $error("B1 loop not closed or echoed");
  b2_loop_a: assert property (
      good_cmd_s(`UMC_CMD_B2_LOOP)
      |=> loop_ctl.b2 && loop_ctl.side && st_r.eoc_tx_r == $past(frm_in.eoc_word))
    else $error("B2 loop not closed or echoed");
  req_crc_a: assert property (
      good_cmd_s(`UMC_CMD_REQ_BAD_CRC) |=> loop_ctl.request_bad_crc_cmd)
    else $error("Corrupt CRC request not latched");
  note_crc_a: assert property (
      good_cmd_s(`UMC_CMD_NOT_BAD_CRC) |=> loop_ctl.notify_bad_crc_cmd)
    else $error("Corrupt CRC notice not latched");
  return_norm_a: assert property (
      good_cmd_s(`UMC_CMD_RETURN)
      |=> loop_ctl == '0 && st_r.eoc_tx_r == `UMC_RST_EOC_TX)
    else $error("Return to normal incomplete");
  hold_keep_a: assert property (
      good_cmd_s(`UMC_CMD_HOLD)
      |=> loop_ctl == $past(loop_ctl) && st_r.eoc_tx_r == $past(frm_in.eoc_word))
    else $error("Hold changed loop state");
  foreign_hold_a: assert property (
      rx_state_ok(line_state) && st_r.rx_en_r && st_r.auto_r && frm_in.eoc_valid &&
      !addr_ours(frm_in.eoc_word.addr) |=> st_r.eoc_tx_r == {`UMC_ADDR_NT, 1'b1, `UMC_CMD_HOLD})
    else $error("Hold not sent for foreign address");
  unable_a: assert property (
      rx_state_ok(line_state) && st_r.rx_en_r && st_r.auto_r && frm_in.eoc_valid &&
      addr_ours(frm_in.eoc_word.addr) && !frm_in.eoc_word.dm |=> st_r.eoc_tx_r.info == `UMC_CMD_UNABLE)
    else $error("Unable-to-comply not sent");

endmodule : umc_maint_core

// *** pkg/umc_map.svh ***
`ifndef UMC_MAP_SVH
`define UMC_MAP_SVH

// Register byte offsets
`define UMC_OFF_EOC_TX      8'h00
`define UMC_OFF_M4_TX       8'h04
`define UMC_OFF_M56_TX      8'h08
`define UMC_OFF_EOC_RX      8'h0C
`define UMC_OFF_M4_RX       8'h10
`define UMC_OFF_M56_RX      8'h14
`define UMC_OFF_STATUS      8'h18
`define UMC_OFF_CTRL        8'h1C
`define UMC_OFF_LOOP        8'h20

// Status bit positions
`define UMC_ST_EOC          0
`define UMC_ST_M4           1
`define UMC_ST_M56          2
`define UMC_ST_T6           3
`define UMC_ST_T12          4

// Control and loop bit positions
`define UMC_CTRL_AUTO       0
`define UMC_LP_FULL         0
`define UMC_LP_B1           1
`define UMC_LP_B2           2
`define UMC_LP_SIDE         3
`define UMC_LP_RCC          4
`define UMC_LP_NCC          5
`define UMC_LP_ARL          6

// Reset values
`define UMC_RST_EOC_TX      12'h0FF
`define UMC_RST_EOC_RX      12'h0FF
`define UMC_RST_M4          8'hFF
`define UMC_RST_M56         2'b11
`define UMC_RST_CTRL        1'b1

// EOC word fields and codes
`define UMC_ADDR_NT         3'b000
`define UMC_ADDR_BCAST      3'b111
`define UMC_CMD_HOLD        8'h00
`define UMC_CMD_FULL_LOOP   8'h50
`define UMC_CMD_B1_LOOP     8'h51
`define UMC_CMD_B2_LOOP     8'h52
`define UMC_CMD_REQ_BAD_CRC 8'h53
`define UMC_CMD_NOT_BAD_CRC 8'h54
`define UMC_CMD_UNABLE      8'hAA
`define UMC_CMD_RETURN      8'hFF

// Basic frame indices (zero based) carrying the timing events
`define UMC_FRAME_FIRST     3'd0
`define UMC_FRAME_FIFTH     3'd4

// Bus responses
`define UMC_RESP_OKAY       2'b00
`define UMC_RESP_SLVERR     2'b10

`endif

// *** pkg/umc_pkg.sv ***
package umc_pkg;

  typedef enum logic [3:0] {
    LS_RESET, LS_DEACTIVATED, LS_TRAINING, LS_SYNC1, LS_SYNC2, LS_WAIT_ACT,
    LS_TRANSPARENT, LS_ERROR_ST, LS_PEND_DEAC_ST, LS_PEND_DEAC_U, LS_ANALOG_LOOP,
    LS_TEST
  } umc_line_state_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } umc_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } umc_axi_rsp_type;

  // EOC word: address, data/message indicator, information
  typedef struct packed {
    logic [2:0] addr;
    logic       dm;
    logic [7:0] info;
  } umc_eoc_type;

  typedef struct packed {
    logic full;
    logic b1;
    logic b2;
    logic side;
    logic request_bad_crc_cmd;
    logic notify_bad_crc_cmd;
    logic loop_request_indication;
  } umc_loop_type;

  typedef struct packed {
    logic        sf_active;
    logic        m_normal;
    logic        frame_start;
    logic [2:0]  frame_num;
    logic        eoc_valid;
    umc_eoc_type eoc_word;
    logic        m4_valid;
    logic [7:0]  m4_bits;
    logic        m56_valid;
    logic [1:0]  m56_bits;
  } umc_frm_in_type;

  typedef struct packed {
    umc_eoc_type eoc;
    logic [7:0]  m4;
    logic [1:0]  m56;
  } umc_tx_type;

endpackage : umc_pkg
